// ===== verilog/cpt_pkg.sv
// constants shared by the port and capture timer block
`default_nettype none

package cpt_pkg;

    // ----------------------------------------------------------------
    // register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_P1_DIR  = 6'h00;
    localparam logic [5:0] IDX_P2_DIR  = 6'h01;
    localparam logic [5:0] IDX_P1_DATA = 6'h02;
    localparam logic [5:0] IDX_P2_DATA = 6'h03;
    localparam logic [5:0] IDX_TIMER_CONTROL_STATUS    = 6'h08;
    localparam logic [5:0] IDX_FRC     = 6'h09;
    localparam logic [5:0] IDX_CAP     = 6'h0d;
    localparam logic [5:0] IDX_SERIAL  = 6'h11;
    localparam logic [5:0] IDX_P5      = 6'h20;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TC_ICF  = 7;
    localparam int TC_OCF  = 6;
    localparam int TC_TOF  = 5;
    localparam int TC_CAPTURE_IRQ_ENABLE = 4;
    localparam int TC_COMPARE_IRQ_ENABLE = 3;
    localparam int TC_OVERFLOW_IRQ_ENABLE = 2;
    localparam int TC_CAPTURE_EDGE_SELECT = 1;
    localparam int TC_OUTPUT_LEVEL_BIT = 0;
    localparam int SER_RE  = 3;
    localparam int SER_TE  = 1;
    localparam int P5_SHARE = 2;
    localparam int P2_FCNT = 0;
    localparam int P2_BAUD = 2;
    localparam int P2_RX   = 3;
    localparam int P2_TX   = 4;
    localparam int P1_SDA  = 3;
    localparam int P1_SCL  = 4;

    // ----------------------------------------------------------------
    // reset values, responses, clock figures
    // ----------------------------------------------------------------
    localparam logic [7:0]  DIR_RST  = 8'h00;
    localparam logic [7:0]  DATA_RST = 8'h00;
    localparam logic [4:0]  TCTL_RST = 5'h00;
    localparam logic [15:0] FRC_RST  = 16'h0000;
    localparam logic [15:0] FRC_TOP  = 16'hffff;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam int PROC_CLK_LO_HZ = 1008000;
    localparam int PROC_CLK_HI_HZ = 2016000;
    localparam int SYNC_STAGES    = 2;

endpackage : cpt_pkg

`default_nettype wire

// ===== verilog/cpt_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none

module cpt_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // ----------------------------------------------------------------
    // first stage feeds only the second
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : cpt_sync

`default_nettype wire

// ===== verilog/cpt_top.sv
// ports, free-running counter and input capture behind an axi4-lite slave
//
// Summary of operation
// - eight-bit port, each bit's direction set by its direction bit
// - direction 0 is input, 1 is output; both clear to input on reset
// - input lines leave their output buffer undriven
// - reset puts every eight-bit port line in the undriven state
// - lines 3 and 4 go to the two-wire controller when port five bit 2
// - eight-bit port never carries address bits, only general i/o
// - five-bit second port with direction bits; only bits 3, 4 are pins
// - serial control overrides second port direction and data
// - 16-bit counter steps every clock it is not written; reading leaves it alone
// - a 16-bit store or load moves both bytes at once
// - capture input is the frequency counter output
// - selected edge copies the counter into the capture register
// - control bit 1: 0 falling, 1 rising capture edge
// - status bit 7 set on capture, cleared by reading capture
// - status bit 5 set on overflow, cleared by reading counter
// - bit 4 enables capture interrupt, bit 2 overflow interrupt
// - no output waveform; bits 6, 3 and 0 do nothing
// - counter clock equals processor bus clock, not divided further
// - in emulation mode core outputs do not drive internal buses
// - non-maskable interrupt held inactive, standby held disabled
`default_nettype none

module cpt_top
    import cpt_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    input  wire logic [7:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    input  wire logic [7:0] port_one_in,
    output logic [7:0]      port_one_out,
    output logic [7:0]      port_one_oe,
    input  wire logic [1:0] port_two_in,
    output logic [1:0]      port_two_out,
    output logic [1:0]      port_two_oe,
    input  wire logic       frequency_counter,
    input  wire logic       baud_clock,
    input  wire logic       serial_tx_data,
    output logic            serial_rx_data,
    input  wire logic [1:0] i2c_out,
    input  wire logic [1:0] i2c_oe,
    output logic [1:0]      i2c_in,
    input  wire logic       emulation_mode,
    output logic            core_bus_oe,
    output logic            core_nmi_n,
    output logic            standby_input_n,
    output logic            interrupt_request_pin
);
    import cpt_pkg::*;

    logic [7:0]  p1_dir;
    logic [7:0]  p1_data;
    logic [4:0]  p2_dir;
    logic [4:0]  p2_data;
    logic [4:0]  tctl;
    logic        capture_flag;
    logic        overflow_flag;
    logic [15:0] free_running_count;
    logic [15:0] cap;
    logic        ser_re;
    logic        ser_te;
    logic        p5_share;
    logic [7:0]  p1_pin;
    logic [1:0]  p2_pin;
    logic        emul;
    logic        fc_q;
    logic        aw_full;
    logic        w_full;
    logic [5:0]  aw_idx;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic        rd_go;
    logic [5:0]  rd_idx;
    logic        frc_wr;
    logic        cap_hit;
    logic        rd_frc;
    logic        rd_cap;
    logic [7:0]  next_p1_oe;
    logic [1:0]  next_p2_oe;
    logic [1:0]  next_p2_out;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    cpt_sync #(.W(8)) u_sync_p1 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (port_one_in),
        .q       (p1_pin)
    );

    cpt_sync #(.W(3)) u_sync_p2 (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({emulation_mode, port_two_in}),
        .q       ({emul, p2_pin})
    );

    // byte address to register index
    function automatic logic [5:0] reg_index(input logic [7:0] addr);
        return addr[7:2];
    endfunction : reg_index

    // ----------------------------------------------------------------
    // axi4-lite slave: one write and one read in flight
    // ----------------------------------------------------------------
    assign wr_go  = aw_full && w_full && !s_axi_bvalid;
    assign rd_go  = s_axi_arvalid && s_axi_arready;
    assign rd_idx = reg_index(s_axi_araddr);
    assign rd_frc = rd_go && (rd_idx == IDX_FRC);
    assign rd_cap = rd_go && (rd_idx == IDX_CAP);
    assign frc_wr = wr_go && (aw_idx == IDX_FRC);

    // address and data are held separately, taken in either order
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_idx        <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_idx  <= reg_index(s_axi_awaddr);
            end else if (wr_go) begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_full <= 1'b0;
            end
            // ready drops the edge an item is taken
            s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_full && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (aw_idx)
                IDX_P1_DIR, IDX_P2_DIR, IDX_P1_DATA, IDX_P2_DATA,
                IDX_TIMER_CONTROL_STATUS, IDX_FRC, IDX_SERIAL, IDX_P5: begin
                    s_axi_bresp <= RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read data registered at the address handshake
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                s_axi_rdata  <= '0;
                case (rd_idx)
                    // direction registers are write-only, read zero
                    IDX_P1_DIR, IDX_P2_DIR: begin
                        s_axi_rdata <= '0;
                    end
                    IDX_P1_DATA: begin
                        s_axi_rdata[7:0] <= (p1_dir & p1_data)
                                          | (~p1_dir & p1_pin);
                    end
                    IDX_P2_DATA: begin
                        s_axi_rdata[P2_FCNT] <= p2_dir[P2_FCNT]
                            ? p2_data[P2_FCNT] : frequency_counter;
                        s_axi_rdata[1] <= p2_dir[1] & p2_data[1];
                        s_axi_rdata[P2_BAUD] <= p2_dir[P2_BAUD]
                            ? p2_data[P2_BAUD] : baud_clock;
                        s_axi_rdata[P2_RX] <= p2_dir[P2_RX]
                            ? p2_data[P2_RX] : p2_pin[0];
                        s_axi_rdata[P2_TX] <= p2_dir[P2_TX]
                            ? p2_data[P2_TX] : p2_pin[1];
                    end
                    IDX_TIMER_CONTROL_STATUS: begin
                        // compare flag always reads zero
                        s_axi_rdata[7:0] <= {capture_flag, 1'b0, overflow_flag, tctl};
                    end
                    IDX_FRC: begin
                        s_axi_rdata[15:0] <= free_running_count;
                    end
                    IDX_CAP: begin
                        s_axi_rdata[15:0] <= cap;
                    end
                    IDX_SERIAL: begin
                        s_axi_rdata[SER_RE] <= ser_re;
                        s_axi_rdata[SER_TE] <= ser_te;
                    end
                    IDX_P5: begin
                        s_axi_rdata[P5_SHARE] <= p5_share;
                    end
                    default: begin
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // port and control registers written by software
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            p1_dir   <= DIR_RST;
            p2_dir   <= DIR_RST[4:0];
            p1_data  <= DATA_RST;
            p2_data  <= DATA_RST[4:0];
            tctl     <= TCTL_RST;
            ser_re   <= 1'b0;
            ser_te   <= 1'b0;
            p5_share <= 1'b0;
        end else if (wr_go && w_strb[0]) begin
            case (aw_idx)
                IDX_P1_DIR:  p1_dir  <= w_data[7:0];
                IDX_P2_DIR:  p2_dir  <= w_data[4:0];
                IDX_P1_DATA: p1_data <= w_data[7:0];
                IDX_P2_DATA: p2_data <= w_data[4:0];
                // bits 3 and 0 are stored but steer nothing
                IDX_TIMER_CONTROL_STATUS:    tctl    <= w_data[4:0];
                IDX_SERIAL: begin
                    ser_re <= w_data[SER_RE];
                    ser_te <= w_data[SER_TE];
                end
                IDX_P5:      p5_share <= w_data[P5_SHARE];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // free-running counter on the processor bus clock
    // ----------------------------------------------------------------
    // sys_clk stands for the undivided bus clock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            free_running_count <= FRC_RST;
        end else if (frc_wr) begin
            // both bytes land together so no carry splits them
            if (w_strb[1]) free_running_count[15:8] <= w_data[15:8];
            if (w_strb[0]) free_running_count[7:0]  <= w_data[7:0];
        end else begin
            free_running_count <= free_running_count + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // input capture from the frequency counter output
    // ----------------------------------------------------------------
    // the counter output is on this clock, so no synchroniser
    assign cap_hit = tctl[TC_CAPTURE_EDGE_SELECT] ? (frequency_counter && !fc_q)
                                   : (!frequency_counter && fc_q);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fc_q <= 1'b0;
            cap  <= FRC_RST;
        end else begin
            fc_q <= frequency_counter;
            if (cap_hit) begin
                cap <= free_running_count;
            end
        end
    end

    // flags: a set in the same cycle as the clearing read wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            capture_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            if (cap_hit) begin
                capture_flag <= 1'b1;
            end else if (rd_cap) begin
                capture_flag <= 1'b0;
            end
            if (!frc_wr && free_running_count == FRC_TOP) begin
                overflow_flag <= 1'b1;
            end else if (rd_frc) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // level request, compare enable ignored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            interrupt_request_pin <= 1'b0;
        end else begin
            interrupt_request_pin <= (capture_flag && tctl[TC_CAPTURE_IRQ_ENABLE])
                                  || (overflow_flag && tctl[TC_OVERFLOW_IRQ_ENABLE]);
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // data only, never address bits
    always_comb begin
        next_p1_oe = p1_dir;
        if (p5_share) begin
            next_p1_oe[P1_SDA] = i2c_oe[0];
            next_p1_oe[P1_SCL] = i2c_oe[1];
        end
        // serial enables beat the port registers
        next_p2_oe[0]  = p2_dir[P2_RX] && !ser_re;
        next_p2_oe[1]  = p2_dir[P2_TX] || ser_te;
        next_p2_out[0] = p2_data[P2_RX];
        next_p2_out[1] = ser_te ? serial_tx_data : p2_data[P2_TX];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_one_oe  <= '0;
            port_one_out <= '0;
            port_two_oe  <= '0;
            port_two_out <= '0;
        end else begin
            port_one_oe  <= next_p1_oe;
            port_one_out <= p1_data;
            if (p5_share) begin
                port_one_out[P1_SDA] <= i2c_out[0];
                port_one_out[P1_SCL] <= i2c_out[1];
            end
            port_two_oe  <= next_p2_oe;
            port_two_out <= next_p2_out;
        end
    end

    // pins seen by serial and two-wire logic; core straps
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serial_rx_data  <= 1'b1;
            i2c_in          <= '0;
            core_bus_oe     <= 1'b0;
            core_nmi_n      <= 1'b1;
            standby_input_n <= 1'b1;
        end else begin
            serial_rx_data  <= p2_pin[0];
            i2c_in          <= {p1_pin[P1_SCL], p1_pin[P1_SDA]};
            core_bus_oe     <= !emul;
            core_nmi_n      <= 1'b1;
            standby_input_n <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_capture_edge;
        cap_hit ##0 !rst;
    endsequence

    property p_reset_hiz;
        @(posedge sys_clk) rst |=> port_one_oe == 8'h00;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz)
        else $error("port one driven after reset");

    property p_input_hiz;
        @(posedge sys_clk) disable iff (rst)
        !p5_share ##1 !rst |-> port_one_oe == $past(p1_dir);
    endproperty
    a_input_hiz: assert property (p_input_hiz)
        else $error("port one enable differs from direction");

    property p_count;
        @(posedge sys_clk) disable iff (rst)
        !frc_wr ##1 !rst |-> free_running_count == $past(free_running_count) + 16'h0001;
    endproperty
    a_count: assert property (p_count)
        else $error("counter did not step by one");

    property p_capture;
        @(posedge sys_clk) disable iff (rst)
        s_capture_edge |=> cap == $past(free_running_count) && capture_flag;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture value or flag wrong");

    property p_icf_clear;
        @(posedge sys_clk) disable iff (rst)
        rd_cap && !cap_hit |=> !capture_flag;
    endproperty
    a_icf_clear: assert property (p_icf_clear)
        else $error("capture flag not cleared by read");

    property p_tof_set;
        @(posedge sys_clk) disable iff (rst)
        free_running_count == 16'hffff && !frc_wr |=> overflow_flag ##1 1'b1;
    endproperty
    a_tof_set: assert property (p_tof_set)
        else $error("overflow flag not set");

    property p_irq;
        @(posedge sys_clk) disable iff (rst)
        capture_flag && tctl[TC_CAPTURE_IRQ_ENABLE] |=> interrupt_request_pin;
    endproperty
    a_irq: assert property (p_irq)
        else $error("capture interrupt missing");

    property p_rx_force;
        @(posedge sys_clk) disable iff (rst)
        ser_re ##1 !rst |-> !port_two_oe[0];
    endproperty
    a_rx_force: assert property (p_rx_force)
        else $error("receive line driven while serial enabled");

    property p_tx_force;
        @(posedge sys_clk) disable iff (rst)
        ser_te |=> port_two_oe[1] && port_two_out[1] == $past(serial_tx_data);
    endproperty
    a_tx_force: assert property (p_tx_force)
        else $error("transmit line not taken by serial");

    property p_emul;
        @(posedge sys_clk) disable iff (rst)
        emul [*2] |-> !core_bus_oe;
    endproperty
    a_emul: assert property (p_emul)
        else $error("core drives bus in emulation");
endmodule : cpt_top

`default_nettype wire

// ===== tb/cpt_freq_model.sv
// frequency counter and baud clock model at the timer's far side
`default_nettype none

module cpt_freq_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic level_req,
    output logic      frequency_counter,
    output logic      baud_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div;
    // counter output follows the level asked for, one edge late
    always_ff @(posedge sys_clk) begin
        frequency_counter <= rst ? 1'b0 : level_req;
    end
    // short divider keeps the baud clock moving in a brief run
    always_ff @(posedge sys_clk) begin
        div        <= rst ? 3'h0 : div + 3'h1;
        baud_clock <= div[2];
    end
endmodule : cpt_freq_model

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the port and capture timer block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cpt_pkg::*;
    logic        sys_clk, rst, lvl, emu, awv, wv, bre, arv, rre;
    logic        awr, wr, bv, arr, rv, fc, bd, cbo, nmi, stb, irq, rxd;
    logic [7:0]  awa, ara, p1o, p1e, p1x;
    logic [31:0] wd, rd, rdv;
    logic [15:0] a, c1, c2;
    logic [1:0]  br, rr, rs, p2o, p2e, i2e, i2i;
    int          fail_count, checks, cyc, ta, tar;
    // pins resolved: driven bits read back, others see the outside level
    wire  [7:0]  p1i = (p1e & p1o) | (~p1e & p1x);

    cpt_top dut (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .port_one_in(p1i), .port_one_out(p1o),
        .port_one_oe(p1e), .port_two_in(2'h3), .port_two_out(p2o),
        .port_two_oe(p2e), .frequency_counter(fc), .baud_clock(bd),
        .serial_tx_data(1'b1), .serial_rx_data(rxd), .i2c_out(~i2e),
        .i2c_oe(i2e), .i2c_in(i2i), .emulation_mode(emu),
        .core_bus_oe(cbo), .core_nmi_n(nmi), .standby_input_n(stb),
        .interrupt_request_pin(irq));
    cpt_freq_model fm (.sys_clk(sys_clk), .rst(rst), .level_req(lvl),
        .frequency_counter(fc), .baud_clock(bd));

    // ----------------------------------------------------------------
    // clock, cycle count, bus tasks
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [5:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        awa <= {idx, 2'h0};
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        rs = br;
        bre <= 1'b0;
    endtask : wr_reg
    // cycle of the address handshake kept to reckon counter steps
    task automatic rd_reg(input logic [5:0] idx);
        @(posedge sys_clk);
        ara <= {idx, 2'h0};
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arr && arv) begin
                arv <= 1'b0;
                tar = cyc;
            end
        end while (rv !== 1'b1);
        rdv = rd;
        rs  = rr;
        rre <= 1'b0;
    endtask : rd_reg

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_ports;
        chk(p1e, 8'h00);
        chk({nmi, stb, irq}, 3'b110);
        wr_reg(IDX_P1_DIR, 32'hf0);
        wr_reg(IDX_P1_DATA, 32'ha5);
        repeat (2) @(posedge sys_clk);
        chk(p1e, 8'hf0);
        chk(p1o & p1e, 8'ha0);
        rd_reg(IDX_P1_DATA);
        chk(rdv[3:0], 4'ha);
        // two-wire side drives line 3 low, leaves line 4 to the pin
        wr_reg(IDX_P5, 32'h04);
        repeat (2) @(posedge sys_clk);
        chk(p1e, 8'he8);
        chk(p1o, 8'hb5);
        wr_reg(IDX_P2_DIR, 32'h18);
        wr_reg(IDX_P2_DATA, 32'h18);
        repeat (2) @(posedge sys_clk);
        chk({p2e, p2o}, 4'hf);
        chk({rxd, i2i}, 3'b110);
        rd_reg(IDX_P2_DATA);
        chk({rdv[4:3], rdv[1:0]}, 4'hc);
        wr_reg(IDX_SERIAL, 32'h08);
        repeat (2) @(posedge sys_clk);
        chk(p2e, 2'b10);
        wr_reg(IDX_P2_DATA, 32'h00);
        wr_reg(IDX_SERIAL, 32'h02);
        repeat (2) @(posedge sys_clk);
        chk({p2e, p2o}, 4'he);
        wr_reg(6'h3f, 32'hff);
        chk(rs, RESP_SLVERR);
        $display("test ports done");
    endtask : t_ports
    task automatic t_timer;
        rd_reg(IDX_FRC);
        a  = rdv[15:0];
        ta = tar;
        rd_reg(IDX_FRC);
        chk(16'(rdv[15:0] - a), 16'(tar - ta));
        wr_reg(IDX_TIMER_CONTROL_STATUS, 32'hff);
        rd_reg(IDX_TIMER_CONTROL_STATUS);
        chk(rdv[7:0], 8'h1f);
        wr_reg(IDX_TIMER_CONTROL_STATUS, 32'h04);
        wr_reg(IDX_FRC, 32'hfff0);
        repeat (24) @(posedge sys_clk);
        chk(irq, 1'b1);
        rd_reg(IDX_TIMER_CONTROL_STATUS);
        chk(rdv[7:0], 8'h24);
        rd_reg(IDX_FRC);
        chk(rdv[15:8], 8'h00);
        chk(rs, RESP_OKAY);
        rd_reg(IDX_TIMER_CONTROL_STATUS);
        chk(rdv[7:0], 8'h04);
        chk(irq, 1'b0);
        $display("test timer done");
    endtask : t_timer
    // the unselected transition comes first and must not capture
    task automatic t_capture;
        for (int e = 0; e < 2; e++) begin
            lvl <= e[0];
            wr_reg(IDX_TIMER_CONTROL_STATUS, {27'h0, 3'h4, e[0], 1'b0});
            lvl <= ~e[0];
            repeat (4) @(posedge sys_clk);
            rd_reg(IDX_TIMER_CONTROL_STATUS);
            chk(rdv[7], 1'b0);
            rd_reg(IDX_FRC);
            c1 = rdv[15:0];
            lvl <= e[0];
            repeat (4) @(posedge sys_clk);
            rd_reg(IDX_FRC);
            c2 = rdv[15:0];
            chk(irq, 1'b1);
            rd_reg(IDX_TIMER_CONTROL_STATUS);
            chk(rdv[7], 1'b1);
            rd_reg(IDX_CAP);
            chk(rdv[15:0] > c1 && rdv[15:0] < c2, 1'b1);
            rd_reg(IDX_TIMER_CONTROL_STATUS);
            chk(rdv[7], 1'b0);
        end
        emu <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk(cbo, 1'b0);
        emu <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk(cbo, 1'b1);
        $display("test capture and emulation done");
    endtask : t_capture
    task automatic give_verdict;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // reset held two edges; synchroniser flops clear while it stands
    initial begin
        {rst, lvl, emu, awv, wv, bre, arv, rre} = 8'h80;
        {awa, ara, wd, p1x} = {16'h0, 32'h0, 8'h5a};
        i2e = 2'h1;
        {fail_count, checks, cyc} = {32'd0, 32'd0, 32'd0};
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_ports();
        t_timer();
        t_capture();
        give_verdict();
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
